// ==== jtsm_mapper.v ====
// Transport-layer sample mapper: packs samples into two links of lanes
`timescale 1ns/1ps
`default_nettype none
`include "jtsm_consts.vh"
module jtsm_mapper (
    input  wire                                CLK,
    input  wire                                NRST,
    input  wire [`JTSM_SEL_W-1:0]              LINK_FORMAT_SELECT,
    input  wire [`JTSM_THR_W-1:0]              OVERRANGE_THRESHOLD_ZERO,
    input  wire [`JTSM_THR_W-1:0]              OVERRANGE_THRESHOLD_ONE,
    input  wire                                IN_VALID,
    output wire                                IN_READY,
    input  wire [`JTSM_SLOTS*`JTSM_SMP_W-1:0]  IN_SAMPLES,
    input  wire [`JTSM_PAIRS*`JTSM_CVT_W-1:0]  IN_INPHASE,
    input  wire [`JTSM_PAIRS*`JTSM_CVT_W-1:0]  IN_QUADRATURE,
    output wire                                OUT_VALID,
    input  wire                                OUT_READY,
    output wire [`JTSM_LANES*`JTSM_LANE_W-1:0] LINK_A_LANE,
    output wire [`JTSM_LANES*`JTSM_LANE_W-1:0] LINK_B_LANE,
    output wire [2*`JTSM_LANES-1:0]            LANE_ENABLE,
    output wire                                FORMAT_INVALID
);
    // Format kinds, one-hot
    localparam [6:0] K_S8   = 7'h01;
    localparam [6:0] K_S16  = 7'h02;
    localparam [6:0] K_D8   = 7'h04;
    localparam [6:0] K_D16  = 7'h08;
    localparam [6:0] K_CSGL = 7'h10;
    localparam [6:0] K_CDUL = 7'h20;
    localparam [6:0] K_NONE = 7'h40;

    localparam integer LW   = `JTSM_LANE_W;
    localparam integer SW   = `JTSM_SMP_W;
    localparam integer CW   = `JTSM_CVT_W;
    localparam integer WW   = `JTSM_WORD_W;
    localparam integer NL   = `JTSM_LANES;
    localparam integer BUFW = 2 * NL * LW + 2 * NL + 1;

    // Map a format value to its layout kind
    function [6:0] kind_of;
        input [`JTSM_SEL_W-1:0] sel;
        begin
            case (sel)
                `JTSM_SEL_S8A:      kind_of = K_S8;
                `JTSM_SEL_S8B:      kind_of = K_S8;
                `JTSM_SEL_S16:      kind_of = K_S16;
                `JTSM_SEL_D8A:      kind_of = K_D8;
                `JTSM_SEL_D8B:      kind_of = K_D8;
                `JTSM_SEL_D16A:     kind_of = K_D16;
                `JTSM_SEL_D16B:     kind_of = K_D16;
                `JTSM_SEL_CVT_SGL:  kind_of = K_CSGL;
                `JTSM_SEL_CVT_DUAL: kind_of = K_CDUL;
                default:            kind_of = K_NONE;
            endcase
        end
    endfunction

    // Lanes in use on each link for a kind
    function integer lanes_used;
        input [6:0] kind;
        begin
            case (kind)
                K_S16:   lanes_used = 8;
                K_D16:   lanes_used = 8;
                K_S8:    lanes_used = 4;
                K_D8:    lanes_used = 4;
                K_CSGL:  lanes_used = 4;
                K_CDUL:  lanes_used = 4;
                default: lanes_used = 0;
            endcase
        end
    endfunction

    // Input slot of sample j on lane k of a link (link 0 is A)
    function integer slot_of;
        input [6:0] kind;
        input integer link;
        input integer k;
        input integer j;
        begin
            case (kind)
                K_S8:    slot_of = 2 * k + link + 8 * j;
                K_S16:   slot_of = 2 * k + link + 16 * j;
                K_D8:    slot_of = link * `JTSM_DUAL_SLOT_B + k + 4 * j;
                K_D16:   slot_of = link * `JTSM_DUAL_SLOT_B + k + 8 * j;
                default: slot_of = 0;
            endcase
        end
    endfunction

    // Complex pair carried in word pair j on lane k of a link
    function integer pair_of;
        input [6:0] kind;
        input integer link;
        input integer k;
        input integer j;
        begin
            case (kind)
                K_CSGL:  pair_of = 2 * k + link + 8 * j;
                K_CDUL:  pair_of = link * `JTSM_DUAL_PAIR_B + k + 4 * j;
                default: pair_of = 0;
            endcase
        end
    endfunction

    // Two's complement core sample to offset binary: flip the sign bit
    function [SW-1:0] offset_bin;
        input [SW-1:0] smp;
        begin
            offset_bin = {~smp[SW-1], smp[SW-2:0]};
        end
    endfunction

    // Converter word: data in the upper fifteen bits, flag at the bottom
    function [WW-1:0] cvt_word;
        input [CW-1:0] data;
        input          flag;
        begin
            cvt_word = {data, flag};
        end
    endfunction

    // Top bit of a field that starts off bits into lane `lane`
    function integer field_top;
        input integer lane;
        input integer off;
        begin
            field_top = lane * LW + LW - 1 - off;
        end
    endfunction

    // Layout kind and per-pair overrange flags
    wire [6:0]                     kind;
    wire                           fmt_bad;
    wire [`JTSM_PAIRS-1:0]         ovr_zero;
    wire [`JTSM_PAIRS-1:0]         ovr_one;
    // Buffer side: the whole frame with its enables and invalid mark
    wire                           buf_ready_q;
    wire [BUFW-1:0]                buf_in;
    wire [BUFW-1:0]                buf_out_q;
    // One candidate frame per layout family, then the chosen one
    reg  [NL*LW-1:0]               byp_a;
    reg  [NL*LW-1:0]               byp_b;
    reg  [NL*LW-1:0]               cvt_a;
    reg  [NL*LW-1:0]               cvt_b;
    reg  [NL*LW-1:0]               pack_a;
    reg  [NL*LW-1:0]               pack_b;
    reg  [2*NL-1:0]                lane_en;
    reg  [SW-1:0]                  smp_a;
    reg  [SW-1:0]                  smp_b;
    reg  [CW-1:0]                  ia;
    reg  [CW-1:0]                  qa;
    reg  [CW-1:0]                  ib;
    reg  [CW-1:0]                  qb;
    // Loop indices, one set per process so each has a single driver
    integer                        ek;
    integer                        eused;
    integer                        k;
    integer                        j;
    integer                        used;
    integer                        sa;
    integer                        sb;
    integer                        top;
    integer                        ck;
    integer                        cj;
    integer                        cused;
    integer                        pa;
    integer                        pb;
    integer                        ctop;

    assign kind = kind_of(LINK_FORMAT_SELECT);

    // Unlisted values send an all-zero frame with the mark set
    assign fmt_bad = (kind == K_NONE);
    assign buf_in  = {fmt_bad, lane_en, pack_b, pack_a};

    // One detector per complex pair; the pair index names the channel
    genvar g;
    generate
        for (g = 0; g < `JTSM_PAIRS; g = g + 1) begin : g_ovr
            jtsm_ovr_det u_det (
                .inphase     (IN_INPHASE[g*CW +: CW]),
                .quadrature  (IN_QUADRATURE[g*CW +: CW]),
                .thresh_zero (OVERRANGE_THRESHOLD_ZERO),
                .thresh_one  (OVERRANGE_THRESHOLD_ONE),
                .flag_zero   (ovr_zero[g]),
                .flag_one    (ovr_one[g])
            );
        end
    endgenerate

    // Lowest lanes of each link on, the rest held off and zero
    always @* begin
        lane_en = `JTSM_EN_RST;
        eused = lanes_used(kind);
        for (ek = 0; ek < NL; ek = ek + 1) begin
            if (ek < eused) begin
                lane_en[ek]      = 1'b1;
                lane_en[NL + ek] = 1'b1;
            end
        end
    end

    // Twelve-bit fields at nibbles 0,3,6,9,12; the tail nibble stays zero
    always @* begin
        byp_a = `JTSM_LANE_RST;
        byp_b = `JTSM_LANE_RST;
        smp_a = {SW{1'b0}};
        smp_b = {SW{1'b0}};
        sa = 0;
        sb = 0;
        top = 0;
        used = lanes_used(kind);
        for (k = 0; k < NL; k = k + 1) begin
            for (j = 0; j < `JTSM_SMP_PER_LANE; j = j + 1) begin
                if (k < used) begin
                    sa = slot_of(kind, 0, k, j);
                    sb = slot_of(kind, 1, k, j);
                    smp_a = offset_bin(IN_SAMPLES[sa*SW +: SW]);
                    smp_b = offset_bin(IN_SAMPLES[sb*SW +: SW]);
                    top = field_top(k, SW * j);
                    byp_a[top -: SW] = smp_a;
                    byp_b[top -: SW] = smp_b;
                end
            end
        end
    end

    // Four sixteen-bit words per lane, I Q I Q; this layout has no tail
    always @* begin
        cvt_a = `JTSM_LANE_RST;
        cvt_b = `JTSM_LANE_RST;
        ia = {CW{1'b0}};
        qa = {CW{1'b0}};
        ib = {CW{1'b0}};
        qb = {CW{1'b0}};
        pa = 0;
        pb = 0;
        ctop = 0;
        cused = lanes_used(kind);
        for (ck = 0; ck < NL; ck = ck + 1) begin
            for (cj = 0; cj < `JTSM_PAIR_PER_LANE; cj = cj + 1) begin
                if (ck < cused) begin
                    pa = pair_of(kind, 0, ck, cj);
                    pb = pair_of(kind, 1, ck, cj);
                    ia = IN_INPHASE[pa*CW +: CW];
                    qa = IN_QUADRATURE[pa*CW +: CW];
                    ib = IN_INPHASE[pb*CW +: CW];
                    qb = IN_QUADRATURE[pb*CW +: CW];
                    ctop = field_top(ck, 2 * WW * cj);
                    // I word carries flag zero, Q word flag one
                    cvt_a[ctop -: WW] =
                        cvt_word(ia, ovr_zero[pa]);
                    cvt_a[ctop - WW -: WW] =
                        cvt_word(qa, ovr_one[pa]);
                    cvt_b[ctop -: WW] =
                        cvt_word(ib, ovr_zero[pb]);
                    cvt_b[ctop - WW -: WW] =
                        cvt_word(qb, ovr_one[pb]);
                end
            end
        end
    end

    // Pick the family of the current kind; an unlisted value stays zero
    always @* begin
        pack_a = `JTSM_LANE_RST;
        pack_b = `JTSM_LANE_RST;
        case (kind)
            K_S8, K_S16, K_D8, K_D16: begin
                pack_a = byp_a;
                pack_b = byp_b;
            end
            K_CSGL, K_CDUL: begin
                pack_a = cvt_a;
                pack_b = cvt_b;
            end
            default: begin
                pack_a = `JTSM_LANE_RST;
                pack_b = `JTSM_LANE_RST;
            end
        endcase
    end

    // Enables and the invalid mark travel with their frame, so a
    // format change never splits a frame between two layouts
    jtsm_pair_buf #(
        .W (BUFW)
    ) u_buf (
        .clk         (CLK),
        .nrst        (NRST),
        .in_valid    (IN_VALID),
        .in_ready_q  (buf_ready_q),
        .in_data     (buf_in),
        .out_valid_q (OUT_VALID),
        .out_ready   (OUT_READY),
        .out_data_q  (buf_out_q)
    );

    assign IN_READY       = buf_ready_q;
    assign LINK_A_LANE    = buf_out_q[NL*LW-1:0];
    assign LINK_B_LANE    = buf_out_q[2*NL*LW-1:NL*LW];
    assign LANE_ENABLE    = buf_out_q[2*NL*LW +: 2*NL];
    assign FORMAT_INVALID = buf_out_q[BUFW-1];
endmodule // jtsm_mapper
`default_nettype wire

// ==== jtsm_consts.vh ====
// Constants of the transport-layer sample mapper
// Overview of operation
// - Frame packing follows selected link format
// - Bypass packs twelve-bit offset-binary samples
// - Converter words: fifteen data bits, overrange bit
// - All tail bits are driven zero
// - Every field is sent MSB first
// - Single-channel bypass interleaves one sequence across links
// - Dual bypass keeps channels on separate lanes
// - Dual converter mode carries both I/Q streams
// - Single converter mode carries one I/Q stream
// - First channel flags against both thresholds
// - Second channel flags against both thresholds
// - Single channel flags against both thresholds
// - Modes 0/30: eight lanes, stride eight
// - Mode 1: sixteen lanes, stride sixteen
// - Sixteen lanes form links A and B
// - Lowest lanes used, the rest powered down
// - Nine format values; others are invalid
`ifndef JTSM_CONSTS_VH
`define JTSM_CONSTS_VH

// Link format select values
`define JTSM_SEL_W        7
`define JTSM_SEL_S8A      7'h00
`define JTSM_SEL_S8B      7'h1E
`define JTSM_SEL_S16      7'h01
`define JTSM_SEL_D8A      7'h02
`define JTSM_SEL_D8B      7'h28
`define JTSM_SEL_D16A     7'h03
`define JTSM_SEL_D16B     7'h1F
`define JTSM_SEL_CVT_DUAL 7'h3A
`define JTSM_SEL_CVT_SGL  7'h3F

// Field layout
`define JTSM_SMP_W        12
`define JTSM_CVT_W        15
`define JTSM_WORD_W       16
`define JTSM_LANE_W       64
`define JTSM_LANES        8
`define JTSM_SLOTS        80
`define JTSM_PAIRS        16
`define JTSM_THR_W        8
`define JTSM_MAG_LSB      7
`define JTSM_SMP_PER_LANE 5
`define JTSM_PAIR_PER_LANE 2
`define JTSM_DUAL_SLOT_B  40
`define JTSM_DUAL_PAIR_B  8
`define JTSM_TAIL_W       4

// Reset values
`define JTSM_LANE_RST     512'h0
`define JTSM_EN_RST       16'h0000

`endif

// ==== jtsm_pair_buf.v ====
// Two-entry buffer with registered outputs on both sides
`timescale 1ns/1ps
`default_nettype none
module jtsm_pair_buf #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         nrst,
    input  wire         in_valid,
    output reg          in_ready_q,
    input  wire [W-1:0] in_data,
    output reg          out_valid_q,
    input  wire         out_ready,
    output reg  [W-1:0] out_data_q
);
    reg [W-1:0] skid_data_q;
    reg         skid_valid_q;
    reg         skid_valid_d;
    wire        push;
    wire        pop;

    assign push = in_valid & in_ready_q;
    assign pop  = out_valid_q & out_ready;

    // Skid entry fills only when the output stage is held
    always @* begin
        skid_valid_d = skid_valid_q;
        if (!out_valid_q || pop) begin
            skid_valid_d = 1'b0;
        end else if (push) begin
            skid_valid_d = 1'b1;
        end
    end

    // Ready is registered so a stall never reaches the source late
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_valid_q  <= 1'b0;
            out_data_q   <= {W{1'b0}};
            skid_data_q  <= {W{1'b0}};
            skid_valid_q <= 1'b0;
            in_ready_q   <= 1'b0;
        end else begin
            skid_valid_q <= skid_valid_d;
            in_ready_q   <= ~skid_valid_d;
            if (!out_valid_q || pop) begin
                if (skid_valid_q) begin
                    out_data_q  <= skid_data_q;
                    out_valid_q <= 1'b1;
                end else if (push) begin
                    out_data_q  <= in_data;
                    out_valid_q <= 1'b1;
                end else begin
                    out_valid_q <= 1'b0;
                end
            end else if (push) begin
                skid_data_q <= in_data;
            end
        end
    end
endmodule // jtsm_pair_buf
`default_nettype wire

// ==== jtsm_ovr_det.v ====
// Overrange detector for one complex converter sample
`timescale 1ns/1ps
`default_nettype none
`include "jtsm_consts.vh"
module jtsm_ovr_det (
    input  wire [`JTSM_CVT_W-1:0] inphase,
    input  wire [`JTSM_CVT_W-1:0] quadrature,
    input  wire [`JTSM_THR_W-1:0] thresh_zero,
    input  wire [`JTSM_THR_W-1:0] thresh_one,
    output wire                   flag_zero,
    output wire                   flag_one
);
    wire [`JTSM_CVT_W-1:0] mag_i;
    wire [`JTSM_CVT_W-1:0] mag_q;
    wire [`JTSM_CVT_W-1:0] mag;
    wire [`JTSM_THR_W-1:0] mag_top;

    // Magnitude of each part; the larger one decides
    assign mag_i = inphase[`JTSM_CVT_W-1] ? (~inphase + 15'h0001) : inphase;
    assign mag_q = quadrature[`JTSM_CVT_W-1] ?
                   (~quadrature + 15'h0001) : quadrature;
    assign mag   = (mag_i > mag_q) ? mag_i : mag_q;
    assign mag_top = mag[`JTSM_MAG_LSB +: `JTSM_THR_W];

    // Strictly above the threshold raises the flag
    assign flag_zero = mag_top > thresh_zero;
    assign flag_one  = mag_top > thresh_one;
endmodule // jtsm_ovr_det
`default_nettype wire

// ==== jtsm_mapper_monitor.sv ====
// Port checker for the transport sample mapper, bound to its top
`timescale 1ns/1ps
`default_nettype none
module jtsm_mapper_monitor (
    input wire logic         CLK,
    input wire logic         NRST,
    input wire logic         IN_VALID,
    input wire logic         IN_READY,
    input wire logic         OUT_VALID,
    input wire logic         OUT_READY,
    input wire logic [511:0] LINK_A_LANE,
    input wire logic [511:0] LINK_B_LANE,
    input wire logic [15:0]  LANE_ENABLE,
    input wire logic         FORMAT_INVALID
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic [15:0] live;
    logic [7:0]  tails;
    // Per lane: any bit set, and any tail bit set on either link
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            live[i]   = |LINK_A_LANE[64*i+:64];
            live[i+8] = |LINK_B_LANE[64*i+:64];
            tails[i]  = |{LINK_A_LANE[64*i+:4], LINK_B_LANE[64*i+:4]};
        end
    end
    a_first_answer:
    assert property (IN_VALID && IN_READY && !OUT_VALID |=> OUT_VALID)
        else $error("taken frame not offered one cycle later");
    a_stall_hold:
    assert property (OUT_VALID && !OUT_READY |=> OUT_VALID
        && $stable(LINK_A_LANE) && $stable(LINK_B_LANE))
        else $error("offered frame changed during a stall");
    a_full_refuse:
    assert property (IN_VALID && IN_READY && !OUT_READY ##1
        IN_VALID && IN_READY && !OUT_READY |=> !IN_READY)
        else $error("full buffer still ready");
    a_tail_zero:
    assert property (OUT_VALID && &LANE_ENABLE |-> tails == 8'h00)
        else $error("tail bits not zero");
    a_off_lanes:
    assert property (OUT_VALID |-> (live & ~LANE_ENABLE) == 16'h0000)
        else $error("powered-down lane carries data");
    a_invalid_quiet:
    assert property (OUT_VALID && FORMAT_INVALID
        |-> LANE_ENABLE == 16'h0000 && live == 16'h0000)
        else $error("unlisted format produced lane data");
    a_link_groups:
    assert property (OUT_VALID && !FORMAT_INVALID
        |-> LANE_ENABLE[15:8] == LANE_ENABLE[7:0]
        && LANE_ENABLE[7:0] inside {8'h0F, 8'hFF})
        else $error("lane enables not lowest lanes of both links");
    a_reset_ready:
    assert property ($rose(NRST) |=> IN_READY && !OUT_VALID)
        else $error("not ready one edge after reset release");
endmodule // jtsm_mapper_monitor
bind jtsm_mapper jtsm_mapper_monitor u_mon (.CLK(CLK), .NRST(NRST),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .LINK_A_LANE(LINK_A_LANE),
    .LINK_B_LANE(LINK_B_LANE), .LANE_ENABLE(LANE_ENABLE),
    .FORMAT_INVALID(FORMAT_INVALID));
`default_nettype wire

// ==== jtsm_rx_model.sv ====
// Receiver model that takes whole frames from both links
`timescale 1ns/1ps
`default_nettype none
module jtsm_rx_model (
    input  wire logic         clk,
    input  wire logic         stall,
    input  wire logic         out_valid,
    output logic              out_ready,
    input  wire logic [511:0] lane_a,
    input  wire logic [511:0] lane_b,
    input  wire logic [15:0]  lane_en,
    input  wire logic         fmt_bad,
    output logic [511:0]      cap_a,
    output logic [511:0]      cap_b,
    output logic [15:0]       cap_en,
    output logic              cap_bad,
    output logic [31:0]       takes
);
    // Bench picks prompt or slow answers; a stall may last any length
    assign out_ready = !stall;
    logic [31:0] cnt = 32'h0;
    assign takes = cnt;
    // Both links taken whole so samples can be rebuilt in index order
    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            cap_a   <= lane_a;
            cap_b   <= lane_b;
            cap_en  <= lane_en;
            cap_bad <= fmt_bad;
            cnt     <= cnt + 32'h1;
        end
    end
endmodule // jtsm_rx_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the transport sample mapper
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, nrst = 0, in_valid = 0, stall = 1, out_ready;
    logic [6:0] fmt = 7'h00, f;
    logic [7:0] thr0 = 8'hFF, thr1 = 8'hFF;
    logic [959:0] smp;
    logic [239:0] ii, qq;
    wire in_ready, out_valid, bad, cbad;
    wire [511:0] la, lb, ca, cb;
    wire [15:0] en, cen;
    wire [31:0] takes;
    int err_count = 0, n_tests = 0, cyc = 0;
    // Format, expected enables, expected invalid flag
    logic [23:0] rows [10] = '{{7'h00, 16'h0F0F, 1'b0},
        {7'h1E, 16'h0F0F, 1'b0}, {7'h01, 16'hFFFF, 1'b0},
        {7'h02, 16'h0F0F, 1'b0}, {7'h28, 16'h0F0F, 1'b0},
        {7'h03, 16'hFFFF, 1'b0}, {7'h1F, 16'hFFFF, 1'b0},
        {7'h3A, 16'h0F0F, 1'b0}, {7'h3F, 16'h0F0F, 1'b0},
        {7'h7F, 16'h0000, 1'b1}};
    jtsm_mapper dut (.CLK(clk), .NRST(nrst), .LINK_FORMAT_SELECT(fmt),
        .OVERRANGE_THRESHOLD_ZERO(thr0), .OVERRANGE_THRESHOLD_ONE(thr1),
        .IN_VALID(in_valid), .IN_READY(in_ready), .IN_SAMPLES(smp),
        .IN_INPHASE(ii), .IN_QUADRATURE(qq), .OUT_VALID(out_valid),
        .OUT_READY(out_ready), .LINK_A_LANE(la), .LINK_B_LANE(lb),
        .LANE_ENABLE(en), .FORMAT_INVALID(bad));
    jtsm_rx_model rx (.clk(clk), .stall(stall), .out_valid(out_valid),
        .out_ready(out_ready), .lane_a(la), .lane_b(lb), .lane_en(en),
        .fmt_bad(bad), .cap_a(ca), .cap_b(cb), .cap_en(cen),
        .cap_bad(cbad), .takes(takes));
    initial forever #2 clk = ~clk;
    function automatic logic [11:0] sv(int n);
        return 12'(n * 37 + 5);
    endfunction
    // Boundary, above-zero and above-both magnitudes cycle by pair
    function automatic logic [14:0] iv(int n);
        return n % 4 == 0 ? 15'h0800 : n % 4 == 1 ? 15'h0900 :
            n % 4 == 2 ? 15'h5F00 : 15'(n);
    endfunction
    function automatic logic [14:0] qv(int n);
        return 15'(n * 17);
    endfunction
    function automatic logic [63:0] xl(logic [6:0] f, int b, int k);
        logic [63:0] r;
        logic [14:0] a, c, x, y, m;
        int p, st, on;
        r = 64'h0;
        on = 0;
        p = 2 * k + b;
        st = 8;
        case (f)
            7'h00, 7'h1E: on = k < 4;
            7'h01: begin on = 1; st = 16; end
            7'h02, 7'h28: begin on = k < 4; st = 4; p = k + 40 * b; end
            7'h03, 7'h1F: begin on = 1; p = k + 40 * b; end
            default: on = 0;
        endcase
        for (int j = 0; j < 5 && on; j++)
            r[63-12*j-:12] = sv(p + st * j) ^ 12'h800;
        for (int j = 0; j < 2 && k < 4 && (f == 7'h3A || f == 7'h3F); j++) begin
            p = f == 7'h3A ? 8 * b + k + 4 * j : 2 * k + b + 8 * j;
            a = iv(p);
            c = qv(p);
            x = a[14] ? -a : a;
            y = c[14] ? -c : c;
            m = x > y ? x : y;
            r[63-32*j-:32] = {a, m[14:7] > thr0, c, m[14:7] > thr1};
        end
        return r;
    endfunction
    task automatic cmp(logic ok, string m);
        n_tests++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic chk(logic [6:0] f, logic [15:0] e, logic inv);
        logic [63:0] mk;
        // Every bit is compared, converter sign bits included
        mk = '1;
        for (int k = 0; k < 8; k++) begin
            cmp(((ca[64*k+:64] ^ xl(f, 0, k)) & mk) === 64'h0, "lane A");
            cmp(((cb[64*k+:64] ^ xl(f, 1, k)) & mk) === 64'h0, "lane B");
        end
        cmp(cen === e, "lane enables");
        cmp(cbad === inv, "invalid flag");
    endtask
    // Offer a frame and hold it until the edge that takes it
    task automatic send(logic [6:0] f);
        @(negedge clk);
        fmt = f;
        in_valid = 1;
        for (int i = 0; i < 50 && !in_ready; i++) @(negedge clk);
        if (in_ready !== 1'b1) cmp(0, "frame never accepted");
        @(posedge clk);
    endtask
    task automatic recv;
        logic [31:0] t0;
        t0 = takes;
        @(negedge clk);
        stall = 0;
        for (int i = 0; i < 50 && takes == t0; i++) @(negedge clk);
        stall = 1;
        if (takes == t0) cmp(0, "no frame delivered");
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            $display("[FAIL] %0t run timed out", $time);
            close_out();
        end
    end
    initial begin
        for (int n = 0; n < 80; n++) smp[12*n+:12] = sv(n);
        for (int n = 0; n < 16; n++) begin
            ii[15*n+:15] = iv(n);
            qq[15*n+:15] = qv(n);
        end
        repeat (2) @(posedge clk);
        @(negedge clk) nrst = 1;
        foreach (rows[r]) begin
            f = rows[r][23:17];
            send(f);
            @(negedge clk) in_valid = 0;
            recv();
            chk(f, rows[r][16:1], rows[r][0]);
        end
        // Overrange flags, including a magnitude equal to threshold zero
        thr0 = 8'h10;
        thr1 = 8'h40;
        foreach (rows[r]) if (rows[r][23:20] == 4'h7 && !rows[r][0]) begin
            f = rows[r][23:17];
            send(f);
            @(negedge clk) in_valid = 0;
            recv();
            chk(f, 16'h0F0F, 1'b0);
        end
        // Two frames back to back into a stalled receiver, third refused
        send(7'h00);
        send(7'h01);
        @(negedge clk) fmt = 7'h02;
        repeat (3) @(negedge clk);
        cmp(in_ready === 1'b0, "full buffer accepted a frame");
        in_valid = 0;
        recv();
        chk(7'h00, 16'h0F0F, 1'b0);
        send(7'h02);
        @(negedge clk) in_valid = 0;
        recv();
        chk(7'h01, 16'hFFFF, 1'b0);
        recv();
        chk(7'h02, 16'h0F0F, 1'b0);
        // Reset in mid-run with a frame waiting on the outputs
        send(7'h03);
        @(negedge clk) in_valid = 0;
        nrst = 0;
        @(negedge clk);
        cmp(out_valid === 1'b0 && in_ready === 1'b0, "reset idle");
        nrst = 1;
        @(negedge clk);
        cmp(in_ready === 1'b1 && out_valid === 1'b0, "after reset");
        close_out();
    end
endmodule // tb
`default_nettype wire
